// >>> shared/upf_pkg.sv
// Shared constants, types and helpers for the serial packet framer
`default_nettype none
package upf_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;   // Module clock rate
  localparam int unsigned TMO_SEC    = 4;            // Packet timeout, seconds
  localparam int unsigned TMO_CYCLES = CLK_HZ * TMO_SEC;
  localparam int unsigned TMO_W      = 27;           // Timeout counter width

  // Bit rates and their clock divisors (rounded down)
  localparam int unsigned BAUD_0 = 9600;
  localparam int unsigned BAUD_1 = 19200;
  localparam int unsigned BAUD_2 = 38400;
  localparam int unsigned BAUD_3 = 57600;
  localparam int unsigned DIV_W  = 12;
  localparam logic [DIV_W-1:0] DIV_0 = DIV_W'(CLK_HZ / BAUD_0);
  localparam logic [DIV_W-1:0] DIV_1 = DIV_W'(CLK_HZ / BAUD_1);
  localparam logic [DIV_W-1:0] DIV_2 = DIV_W'(CLK_HZ / BAUD_2);
  localparam logic [DIV_W-1:0] DIV_3 = DIV_W'(CLK_HZ / BAUD_3);

  // Character layout: start, eight data, stop
  localparam logic [3:0] STOP_IDX = 4'h9;            // Bit index of stop bit
  localparam logic [3:0] CHAR_END = 4'ha;            // Bits sent per character

  // ---------------------------------------------------------------
  // Packet constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  PRE_BYTE  = 8'h55;         // Preamble byte, ASCII U
  localparam logic [15:0] PING_TYPE_CODE = 16'h504b; // Ping type, two ASCII chars
  localparam logic [15:0] NAK_TYPE  = 16'h1515;      // Error reply type
  localparam logic [7:0]  NAK_LEN   = 8'h02;         // Error reply payload length
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] TYPE_WDEF = 16'h5746;      // Write stored defaults
  localparam logic [15:0] TYPE_SCUR = 16'h5346;      // Set working values
  localparam logic [15:0] TYPE_RDEF = 16'h5246;      // Read stored defaults
  localparam logic [15:0] TYPE_GCUR = 16'h4746;      // Get working values

  // Command classes reported with each frame
  localparam logic [2:0] CMD_OTHER = 3'h0;
  localparam logic [2:0] CMD_WDEF  = 3'h1;
  localparam logic [2:0] CMD_SCUR  = 3'h2;
  localparam logic [2:0] CMD_GCUR  = 3'h3;
  localparam logic [2:0] CMD_RDEF  = 3'h4;

  // Receive parser states
  typedef enum logic [7:0] {
    P_HUNT1 = 8'h01, P_HUNT2 = 8'h02, P_TYH = 8'h04, P_TYL = 8'h08,
    P_LEN   = 8'h10, P_PAY   = 8'h20, P_CRH = 8'h40, P_CRL = 8'h80
  } upf_pst_t;

  // Transmit sequencer states
  typedef enum logic [10:0] {
    T_IDLE = 11'h001, T_PRE1 = 11'h002, T_PRE2 = 11'h004, T_TYH = 11'h008,
    T_TYL  = 11'h010, T_LEN  = 11'h020, T_PAY  = 11'h040, T_CRH = 11'h080,
    T_CRL  = 11'h100, T_PKH  = 11'h200, T_PKL  = 11'h400
  } upf_tst_t;

  // Bitwise checksum step over one byte, most significant bit first
  function automatic logic [15:0] upf_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> hdl/upf_framer.sv
// Serial packet framer: UART, receive parser, reply builder, payload FIFO
//
// How it works
// RULE1: characters are 1 start, 8 data, 1 stop
// RULE2: four selectable bit rates, 9600 to 57600
// RULE3: every packet starts with 0x5555 preamble
// RULE4: multi-byte values go most significant first
// RULE5: two-byte checksum covers bytes after preamble
// RULE6: bad checksum frame is discarded, no action
// RULE7: host sends whole packet within 4 seconds
// RULE8: order: preamble, type, length, payload, checksum
// RULE9: short ping answered with the two type chars
// RULE10: full-format ping is answered as well
// RULE11: length byte counts payload bytes only
// RULE12: two-byte type selects payload layout
// RULE13: checksum is CRC-CCITT, polynomial 0x1021
// RULE14: checksum preset 0xFFFF, no final inversion
// RULE15: write-default command flagged for stored copy
// RULE16: set-current command flagged for working copy
// RULE17: get command flagged to return working values
// RULE18: read command flagged to return stored values
// RULE19: accepted input gets reply, else error reply
// RULE20: bitwise checksum; errors resume preamble hunt
// RULE21: timer restarts at preamble, expiry drops frame
`default_nettype none

module upf_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(D);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage words
    logic [AW-1:0]       wr;    // Write index
    logic [AW-1:0]       rd;    // Read index
    logic [AW:0]         cnt;   // Words held
  } upf_fifo_s_t;

  upf_fifo_s_t s;
  upf_fifo_s_t next_s;
  logic        push;
  logic        pop;

  // Handshakes: full and empty from the word count
  assign in_ready  = (s.cnt != (AW+1)'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == AW'(D-1)) ? '0 : s.wr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd = (s.rd == AW'(D-1)) ? '0 : s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule

module upf_framer #(
  parameter int unsigned TIMEOUT_CYCLES = upf_pkg::TMO_CYCLES
) (
  input  wire logic        mclk,          // Module clock
  input  wire logic        rst,           // Async reset, active high
  input  wire logic [1:0]  baud_sel,      // Bit rate select
  input  wire logic        rxd,           // Serial in from host
  output logic             txd,           // Serial out to host
  output logic [7:0]       rx_data,       // Payload byte
  output logic             rx_data_valid, // Payload byte strobe
  output logic [15:0]      rx_type,       // Type of frame in progress
  output logic [7:0]       rx_len,        // Payload length of frame
  output logic [2:0]       rx_cmd,        // Command class of frame
  output logic             frame_start,   // Preamble seen
  output logic             frame_good,    // Checksum matched
  output logic             frame_bad,     // Checksum wrong or timeout
  input  wire logic        reply_req,     // Start a reply
  input  wire logic [15:0] reply_type,    // Reply type
  input  wire logic [7:0]  reply_len,     // Reply payload length
  input  wire logic        reply_nak,     // Send error reply instead
  output logic             reply_busy,    // Reply or ping answer in progress
  input  wire logic [7:0]  pay_data,      // Reply payload byte
  input  wire logic        pay_valid,     // Reply payload valid
  output logic             pay_ready      // FIFO can take a byte
);
  import upf_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] rcnt;       // Receive bit timer
    logic [3:0]       rbit;       // Receive bit index
    logic [7:0]       rsh;        // Receive shifter
    logic             rbusy;      // Character in progress
    upf_pst_t         pst;        // Parser state
    logic [15:0]      pcrc;       // Running receive checksum
    logic [7:0]       pcnt;       // Payload bytes seen
    logic [7:0]       crc_hi;     // First checksum byte
    logic [TMO_W-1:0] tmo;        // Packet timer
    logic             ping;       // Ping answer pending
    logic [7:0]       rx_data;
    logic             rx_data_valid;
    logic [15:0]      rx_type;
    logic [7:0]       rx_len;
    logic [2:0]       rx_cmd;
    logic             frame_start;
    logic             frame_good;
    logic             frame_bad;
    upf_tst_t         tst;        // Transmit sequencer state
    logic [15:0]      ttype;      // Reply type
    logic [7:0]       tlen;       // Reply length
    logic [7:0]       tcnt;       // Reply payload bytes sent
    logic             tnak;       // Error reply in progress
    logic [15:0]      tnak_pl;    // Rejected type for error payload
    logic [15:0]      tcrc;       // Running transmit checksum
    logic [DIV_W-1:0] tcnt_bit;   // Transmit bit timer
    logic [3:0]       tbit;       // Transmit bit index
    logic [9:0]       tsh;        // Transmit shifter, start first
    logic             tbusy;      // Character on the line
  } upf_s_t;

  upf_s_t           s;
  upf_s_t           next_s;
  logic [DIV_W-1:0] div;
  logic             byte_ok;
  logic [7:0]       b;
  logic             thave;
  logic [7:0]       tbyte;
  logic             tcrc_on;
  logic             fifo_valid;
  logic             fifo_pop;
  logic [7:0]       fifo_data;

  // Bit rate divisor
  // RULE2: rate select
  always_comb
  begin
    unique case (baud_sel)
      2'h0: div = DIV_0;
      2'h1: div = DIV_1;
      2'h2: div = DIV_2;
      2'h3: div = DIV_3;
    endcase
  end

  // ---------------------------------------------------------------
  // Reply payload buffer
  // ---------------------------------------------------------------
  upf_fifo #(.W(8), .D(8)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (pay_data),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Outputs
  assign txd           = s.tbusy ? s.tsh[0] : 1'b1;
  assign rx_data       = s.rx_data;
  assign rx_data_valid = s.rx_data_valid;
  assign rx_type       = s.rx_type;
  assign rx_len        = s.rx_len;
  assign rx_cmd        = s.rx_cmd;
  assign frame_start   = s.frame_start;
  assign frame_good    = s.frame_good;
  assign frame_bad     = s.frame_bad;
  assign reply_busy    = (s.tst != T_IDLE) || s.ping || s.tbusy;

  // Byte offered to the transmitter by the sequencer
  // RULE4: high byte first
  always_comb
  begin
    thave   = 1'b1;
    tcrc_on = 1'b1;
    tbyte   = PRE_BYTE;
    unique case (s.tst)
      T_IDLE: thave = 1'b0;
      T_PRE1, T_PRE2: tcrc_on = 1'b0;
      T_TYH: tbyte = s.ttype[15:8];
      T_TYL: tbyte = s.ttype[7:0];
      T_LEN: tbyte = s.tlen;
      T_PAY:
      begin
        if (s.tnak)
          tbyte = (s.tcnt == '0) ? s.tnak_pl[15:8] : s.tnak_pl[7:0];
        else
        begin
          thave = fifo_valid;
          tbyte = fifo_data;
        end
      end
      T_CRH:
      begin
        tcrc_on = 1'b0;
        tbyte   = s.tcrc[15:8];
      end
      T_CRL:
      begin
        tcrc_on = 1'b0;
        tbyte   = s.tcrc[7:0];
      end
      T_PKH:
      begin
        tcrc_on = 1'b0;
        tbyte   = PING_TYPE_CODE[15:8];
      end
      T_PKL:
      begin
        tcrc_on = 1'b0;
        tbyte   = PING_TYPE_CODE[7:0];
      end
    endcase
  end

  // Payload is pulled from the buffer only as it goes onto the line
  assign fifo_pop = (s.tst == T_PAY) && !s.tnak && !s.tbusy;

  // Receive character and its parse
  assign b       = s.rsh;
  assign byte_ok = s.rbusy && (s.rcnt == '0) && (s.rbit == STOP_IDX) && rxd;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s               = s;
    next_s.rx_data_valid = 1'b0;
    next_s.frame_start   = 1'b0;
    next_s.frame_good    = 1'b0;
    next_s.frame_bad     = 1'b0;

    // Receiver: sample each bit at its middle, LSB first
    // RULE1: 8N1 receive
    if (!s.rbusy)
    begin
      if (!rxd)
      begin
        next_s.rbusy = 1'b1;
        next_s.rcnt  = div >> 1;
        next_s.rbit  = '0;
      end
    end
    else if (s.rcnt != '0)
      next_s.rcnt = s.rcnt - 1'b1;
    else
    begin
      next_s.rcnt = div - 1'b1;
      next_s.rbit = s.rbit + 1'b1;
      if ((s.rbit == '0) && rxd)
        next_s.rbusy = 1'b0;
      else if (s.rbit == STOP_IDX)
        next_s.rbusy = 1'b0;
      else if (s.rbit != '0)
        next_s.rsh = {rxd, s.rsh[7:1]};
    end

    // Start a reply or a ping answer
    // Ahead of the parser, so a ping set this cycle is not lost
    // RULE19: reply or error reply
    if (s.tst == T_IDLE)
    begin
      if (s.ping)
      begin
        next_s.ping = 1'b0;
        next_s.tst  = T_PKH;
      end
      else if (reply_req && !s.tbusy)
      begin
        next_s.tst     = T_PRE1;
        next_s.tnak    = reply_nak;
        next_s.ttype   = reply_nak ? NAK_TYPE : reply_type;
        next_s.tlen    = reply_nak ? NAK_LEN : reply_len;
        next_s.tnak_pl = s.rx_type;
        next_s.tcnt    = '0;
      end
    end

    // Packet timer runs while a frame is open
    if ((s.pst != P_HUNT1) && (s.pst != P_HUNT2))
      next_s.tmo = s.tmo + 1'b1;

    // Parser
    // RULE8: field order
    if (byte_ok)
    begin
      unique case (s.pst)
        // RULE3: preamble hunt
        P_HUNT1: if (b == PRE_BYTE) next_s.pst = P_HUNT2;
        P_HUNT2:
        begin
          next_s.pst = (b == PRE_BYTE) ? P_TYH : P_HUNT1;
          // RULE21: timer restart
          next_s.tmo         = '0;
          // RULE14: checksum preset
          next_s.pcrc        = CRC_INIT;
          next_s.frame_start = (b == PRE_BYTE);
        end
        // RULE12: two-byte type
        P_TYH:
        begin
          next_s.rx_type[15:8] = b;
          next_s.pcrc          = upf_crc(s.pcrc, b);
          next_s.pst           = P_TYL;
        end
        P_TYL:
        begin
          next_s.rx_type[7:0] = b;
          next_s.pcrc         = upf_crc(s.pcrc, b);
          next_s.pst          = P_LEN;
          // RULE9: short ping answered at once
          // RULE10: full ping meets the same answer
          if ({s.rx_type[15:8], b} == PING_TYPE_CODE)
          begin
            next_s.ping = 1'b1;
            next_s.pst  = P_HUNT1;
          end
          // RULE15: write-default class
          // RULE16: set-current class
          // RULE17: get class
          // RULE18: read class
          unique case ({s.rx_type[15:8], b})
            TYPE_WDEF: next_s.rx_cmd = CMD_WDEF;
            TYPE_SCUR: next_s.rx_cmd = CMD_SCUR;
            TYPE_GCUR: next_s.rx_cmd = CMD_GCUR;
            TYPE_RDEF: next_s.rx_cmd = CMD_RDEF;
            default:   next_s.rx_cmd = CMD_OTHER;
          endcase
        end
        // RULE11: payload-only length
        P_LEN:
        begin
          next_s.rx_len = b;
          next_s.pcnt   = '0;
          next_s.pcrc   = upf_crc(s.pcrc, b);
          next_s.pst    = (b == '0) ? P_CRH : P_PAY;
        end
        P_PAY:
        begin
          next_s.rx_data       = b;
          next_s.rx_data_valid = 1'b1;
          next_s.pcrc          = upf_crc(s.pcrc, b);
          next_s.pcnt          = s.pcnt + 1'b1;
          if (s.pcnt + 1'b1 == s.rx_len)
            next_s.pst = P_CRH;
        end
        P_CRH:
        begin
          next_s.crc_hi = b;
          next_s.pst    = P_CRL;
        end
        // RULE5: trailing checksum compare
        // RULE6: mismatch discards frame
        // RULE20: back to preamble hunt
        P_CRL:
        begin
          next_s.frame_good = ({s.crc_hi, b} == s.pcrc);
          next_s.frame_bad  = ({s.crc_hi, b} != s.pcrc);
          next_s.pst        = P_HUNT1;
        end
      endcase
    end
    // RULE21: expiry abandons frame
    // RULE7: host keeps within the window
    else if ((s.pst != P_HUNT1) && (s.pst != P_HUNT2)
             && (s.tmo == TMO_W'(TIMEOUT_CYCLES - 1)))
    begin
      next_s.frame_bad = 1'b1;
      next_s.pst       = P_HUNT1;
    end

    // Transmitter: shift a loaded character out
    // RULE1: 8N1 transmit
    if (s.tbusy)
    begin
      if (s.tcnt_bit != '0)
        next_s.tcnt_bit = s.tcnt_bit - 1'b1;
      else
      begin
        next_s.tcnt_bit = div - 1'b1;
        next_s.tsh      = {1'b1, s.tsh[9:1]};
        next_s.tbit     = s.tbit + 1'b1;
        if (s.tbit == CHAR_END - 1'b1)
          next_s.tbusy = 1'b0;
      end
    end
    else if (thave)
    begin
      next_s.tbusy    = 1'b1;
      next_s.tbit     = '0;
      next_s.tcnt_bit = div - 1'b1;
      next_s.tsh      = {1'b1, tbyte, 1'b0};
      // RULE13: same checksum step on replies
      if (tcrc_on)
        next_s.tcrc = upf_crc(s.tcrc, tbyte);
      unique case (s.tst)
        T_PRE1: next_s.tst = T_PRE2;
        T_PRE2:
        begin
          next_s.tst  = T_TYH;
          next_s.tcrc = CRC_INIT;
        end
        T_TYH: next_s.tst = T_TYL;
        T_TYL: next_s.tst = T_LEN;
        T_LEN: next_s.tst = (s.tlen == '0) ? T_CRH : T_PAY;
        T_PAY:
        begin
          next_s.tcnt = s.tcnt + 1'b1;
          if (s.tcnt + 1'b1 == s.tlen)
            next_s.tst = T_CRH;
        end
        T_CRH: next_s.tst = T_CRL;
        T_PKH: next_s.tst = T_PKL;
        default: next_s.tst = T_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s     <= '0;
      s.pst <= P_HUNT1;
      s.tst <= T_IDLE;
    end
    else
      s <= next_s;
  end
endmodule
`default_nettype wire

// >>> verification/upf_framer_sva.sv
// Port-level assertions for the serial packet framer
`default_nettype none
module upf_framer_sva #(
  parameter int unsigned TIMEOUT_CYCLES = 80_000_000
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [1:0]  baud_sel,
  input wire logic        txd,
  input wire logic [15:0] rx_type,
  input wire logic [2:0]  rx_cmd,
  input wire logic        rx_data_valid,
  input wire logic        frame_start,
  input wire logic        frame_good,
  input wire logic        frame_bad,
  input wire logic        reply_req,
  input wire logic        reply_busy
);
  import upf_pkg::*;
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [31:0] low_run;    // Cycles txd has stayed low
  logic [31:0] since_sof;  // Cycles since the last preamble
  logic [31:0] div;        // Bit period of the selected rate
  logic [2:0]  exp_cmd;    // Command class implied by rx_type
  // Bit period and command class lookups
  always_comb
  begin
    case (baud_sel)
      2'h0: div = 32'(DIV_0);
      2'h1: div = 32'(DIV_1);
      2'h2: div = 32'(DIV_2);
      default: div = 32'(DIV_3);
    endcase
    case (rx_type)
      TYPE_WDEF: exp_cmd = CMD_WDEF;
      TYPE_SCUR: exp_cmd = CMD_SCUR;
      TYPE_GCUR: exp_cmd = CMD_GCUR;
      TYPE_RDEF: exp_cmd = CMD_RDEF;
      default: exp_cmd = CMD_OTHER;
    endcase
  end
  // Low-run and frame-age counters
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      low_run <= 32'h0;
      since_sof <= 32'h0;
    end
    else
    begin
      low_run <= txd ? 32'h0 : low_run + 32'h1;
      since_sof <= frame_start ? 32'h0 : since_sof + 32'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_idle_high: assert property (!reply_busy |-> txd)
    else $error("txd low with no reply in progress");
  a_bit_width: assert property ($rose(txd) |-> low_run != 0 && low_run % div == 0)
    else $error("low run on txd not whole bit periods");
  a_reply_start: assert property (reply_req && !reply_busy |=> reply_busy ##1 !txd)
    else $error("reply did not start on time");
  a_busy_end: assert property ($fell(reply_busy) |-> $past(txd) && $past(txd, 2))
    else $error("busy dropped before stop bit ended");
  a_start_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  a_verdict_excl: assert property (frame_good |-> !frame_bad)
    else $error("good and bad verdict together");
  a_min_frame: assert property (frame_good || frame_bad |-> since_sof >= 45 * div)
    else $error("verdict too soon after preamble");
  a_timeout_max: assert property (frame_bad |-> since_sof <= TIMEOUT_CYCLES + 2)
    else $error("frame dropped later than timeout");
  a_cmd_map: assert property (frame_good || rx_data_valid |-> rx_cmd == exp_cmd)
    else $error("command class does not match type");
endmodule

bind upf_framer upf_framer_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_upf_framer_sva (
  .mclk, .rst, .baud_sel, .txd, .rx_type, .rx_cmd, .rx_data_valid,
  .frame_start, .frame_good, .frame_bad, .reply_req, .reply_busy
);
`default_nettype wire

// >>> verification/upf_host.sv
// Host-side serial model: sends characters on rxd, decodes txd
`default_nettype none
module upf_host #(
  parameter int DIV = 347       // Bit period in clock cycles
) (
  input  wire logic mclk,       // Module clock
  output var logic  rxd,        // Line towards the framer
  input  wire logic txd         // Line from the framer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd = f[i];
      repeat (DIV) @(negedge mclk);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 60 * DIV)
    begin
      @(negedge mclk);
      n++;
    end
    if (n < 60 * DIV)
    begin
      repeat (DIV / 2) @(negedge mclk);
      ok = (txd === 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(negedge mclk);
        b[i] = txd;
      end
      repeat (DIV) @(negedge mclk);
      ok = ok && (txd === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_upf_framer.sv
// Self-checking bench for the serial packet framer
`default_nettype none
module tb_upf_framer;
  timeunit 1ns;
  timeprecision 1ns;
  import upf_pkg::*;
  typedef logic [7:0] upf_bq_t[$];      // Byte stream
  localparam int DIV = int'(DIV_3);     // Bit period at 57600
  localparam int TMO = 22000;           // Shortened packet timeout
  logic        mclk, rst, rxd, txd, rx_data_valid, frame_start, frame_good, frame_bad;
  logic        reply_req, reply_nak, reply_busy, pay_valid, pay_ready;
  logic [1:0]  baud_sel;
  logic [7:0]  rx_data, rx_len, reply_len, pay_data, last_data;
  logic [15:0] rx_type, reply_type;
  logic [2:0]  rx_cmd;
  int          fail_count = 0, n_compared = 0, n_good = 0, n_bad = 0;
  upf_framer #(.TIMEOUT_CYCLES(TMO)) i_upf_framer (
    .mclk, .rst, .baud_sel, .rxd, .txd, .rx_data, .rx_data_valid, .rx_type, .rx_len,
    .rx_cmd, .frame_start, .frame_good, .frame_bad, .reply_req, .reply_type, .reply_len,
    .reply_nak, .reply_busy, .pay_data, .pay_valid, .pay_ready
  );
  upf_host #(.DIV(DIV)) i_upf_host (.mclk, .rxd, .txd);
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Verdict and payload monitor
  always @(negedge mclk)
  begin
    if (frame_good === 1'b1) n_good++;
    if (frame_bad === 1'b1) n_bad++;
    if (rx_data_valid === 1'b1) last_data = rx_data;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bitwise checksum, preset all ones, no final inversion
  function automatic upf_bq_t pkt(input logic [15:0] ty, input upf_bq_t pay);
    upf_bq_t q;
    logic [15:0] c;
    q = {ty[15:8], ty[7:0], 8'(pay.size()), pay};
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {q[i], 8'h00};
      for (int k = 0; k < 8; k++)
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return {PRE_BYTE, PRE_BYTE, q, c[15:8], c[7:0]};
  endfunction
  task automatic send_pkt(input upf_bq_t q);
    foreach (q[i]) i_upf_host.send_byte(q[i]);
  endtask
  task automatic expect_tx(input upf_bq_t q);
    logic [7:0] b;
    logic ok;
    foreach (q[i])
    begin
      i_upf_host.recv_byte(b, ok);
      if (ok !== 1'b1)
      begin
        fail_count++;
        final_report();
      end
      chk("txd byte", 16'(q[i]), 16'(b));
    end
  endtask
  task automatic request(input logic [15:0] ty, input logic [7:0] len, input logic nak);
    int n;
    n = 0;
    while (reply_busy !== 1'b0 && n < 60 * DIV)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 60 * DIV)
    begin
      fail_count++;
      final_report();
    end
    reply_type = ty;
    reply_len = len;
    reply_nak = nak;
    reply_req = 1'b1;
    @(negedge mclk);
    reply_req = 1'b0;
    @(negedge mclk);
    chk("reply busy", 16'h0001, 16'(reply_busy));
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_ping();
    int g;
    g = n_good + n_bad;
    fork
      send_pkt({PRE_BYTE, PRE_BYTE, PING_TYPE_CODE[15:8], PING_TYPE_CODE[7:0]});
      expect_tx({PING_TYPE_CODE[15:8], PING_TYPE_CODE[7:0]});
    join
    chk("ping verdicts", 16'(g), 16'(n_good + n_bad));
  endtask
  task automatic t_fill_reply();
    int k;
    int g;
    upf_bq_t pay;
    upf_bq_t bad;
    k = 0;
    while (pay_ready === 1'b1 && k < 9)
    begin
      pay_data = 8'h10 + 8'(k);
      pay_valid = 1'b1;
      pay.push_back(pay_data);
      @(negedge mclk);
      k++;
    end
    pay_valid = 1'b0;
    chk("fifo depth", 16'h0008, 16'(k));
    request(TYPE_GCUR, 8'h08, 1'b0);
    bad = pkt(TYPE_RDEF, '{});
    bad[6] = bad[6] ^ 8'h01;
    fork
      expect_tx(pkt(TYPE_GCUR, pay));
      begin
        g = n_bad;
        send_pkt(bad);
        chk("bad crc drop", 16'(g + 1), 16'(n_bad));
        chk("read class", 16'(CMD_RDEF), 16'(rx_cmd));
        send_pkt({PRE_BYTE, PRE_BYTE, TYPE_WDEF[15:8], TYPE_WDEF[7:0]});
        chk("write class", 16'(CMD_WDEF), 16'(rx_cmd));
        k = 0;
        while (n_bad == g + 1 && k < TMO)
        begin
          @(negedge mclk);
          k++;
        end
        chk("timeout drop", 16'(g + 2), 16'(n_bad));
        chk("timeout late enough", 16'h0001, 16'(k >= TMO - 21 * DIV));
      end
    join
    chk("fifo empty", 16'h0001, 16'(pay_ready));
  endtask
  task automatic t_nak_good();
    int g;
    g = n_good;
    request(NAK_TYPE, 8'h00, 1'b1);
    fork
      expect_tx(pkt(NAK_TYPE, {TYPE_WDEF[15:8], TYPE_WDEF[7:0]}));
      send_pkt(pkt(TYPE_SCUR, '{8'ha5}));
      begin
        repeat (100) @(negedge mclk);
        reply_nak = 1'b0;
        reply_req = 1'b1;
        @(negedge mclk);
        reply_req = 1'b0;
      end
    join
    chk("good frame", 16'(g + 1), 16'(n_good));
    chk("payload byte", 16'h00a5, 16'(last_data));
    chk("length", 16'h0001, 16'(rx_len));
    chk("type", TYPE_SCUR, rx_type);
    chk("set class", 16'(CMD_SCUR), 16'(rx_cmd));
    repeat (DIV) @(negedge mclk);
    chk("busy refused", 16'h0000, 16'(reply_busy));
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    baud_sel = 2'h3;
    reply_req = 1'b0;
    reply_nak = 1'b0;
    reply_type = 16'h0000;
    reply_len = 8'h00;
    pay_data = 8'h00;
    pay_valid = 1'b0;
    last_data = 8'h00;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    chk("idle txd", 16'h0001, 16'(txd));
    t_ping();
    t_fill_reply();
    t_nak_good();
    final_report();
  end
endmodule
`default_nettype wire
